// [logic/sbrc_pkg.sv]
// Constants, register layout and state type for the standby retention block.
package sbrc_pkg;

  // Register indexes; the byte address is four times the index.
  localparam int IDX_W = 8;
  localparam logic [7:0] IDX_IO_CTRL = 8'h30;
  localparam logic [7:0] IDX_DIAG_CTRL = 8'h31;
  localparam logic [7:0] IDX_SWITCH_CTRL = 8'h32;
  localparam logic [7:0] IDX_STATUS = 8'h33;
  localparam logic [7:0] IDX_MISC = 8'h39;
  localparam int WORD_LSB = 2;

  // Standby configuration register: reset value, writable bits, fields.
  localparam int MISC_W = 16;
  localparam logic [15:0] MISC_RESET = 16'h0000;
  localparam logic [15:0] MISC_WR_MASK = 16'he1ff;
  localparam int ROUTE_BIT = 8;
  localparam int DIAG_KEEP_BIT = 7;
  localparam int OUT_KEEP_BIT = 6;
  localparam int SW_KEEP_BIT = 5;

  // Output control register: enables in the low byte, values above.
  localparam int FIELD_W = 8;
  localparam int IO_OE_LSB = 0;
  localparam int IO_VAL_LSB = 8;
  localparam int PIN2_INDEX = 2;

  // Diagnostic control register: error enables and clock select.
  localparam int ERR_LSB = 0;
  localparam int ERR_OV_BIT = 0;
  localparam int ERR_UV_BIT = 1;
  localparam int CLK_LSB = 8;
  localparam int CLK_W = 2;
  localparam logic [1:0] CLK_INTERNAL = 2'h0;

  // Switch control register: one switch setting per channel.
  localparam int SW_SET_LSB = 0;

  // Status register fields.
  localparam int ST_STANDBY = 0;
  localparam int ST_OSC = 1;
  localparam int ST_SWITCH = 2;
  localparam int ST_ROUTE = 3;
  localparam int ST_PIN_LSB = 8;
  localparam int ST_OE_LSB = 16;

  // Bus constants.
  localparam int TRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // Bus slave phases.
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ_WAIT = 2'b10,
    BUS_READ_DONE = 2'b11
  } sbrc_bus_state_type;

endpackage

// [logic/sbrc_output_stage.sv]
// Registered general output pin stage with standby gating and routing.
module sbrc_output_stage #(
  parameter int NUM_PINS = 4
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_standby,
  input wire logic i_route_en,
  input wire logic i_outputs_keep,
  input wire logic [NUM_PINS-1:0] i_pin_oe,
  input wire logic [NUM_PINS-1:0] i_pin_value,
  output logic [NUM_PINS-1:0] o_pin_out,
  output logic [NUM_PINS-1:0] o_pin_oe
);

  // Pin 2 must exist for the standby indication to be routed.
  if (NUM_PINS <= sbrc_pkg::PIN2_INDEX) begin : g_bad_pins
    $error("sbrc_output_stage needs more than two pins");
  end

  genvar p;
  for (p = 0; p < NUM_PINS; p++) begin : g_pin
    // Each pin is driven from a flip-flop so it never glitches on decode.
    always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
        o_pin_out[p] <= 1'b0;
        o_pin_oe[p] <= 1'b0;
      end else if (p == sbrc_pkg::PIN2_INDEX && i_route_en) begin
        // Routed pin ignores its own fields: low in standby, high else.
        o_pin_oe[p] <= 1'b1;
        o_pin_out[p] <= !i_standby;
      end else if (i_standby && !i_outputs_keep) begin
        // Outputs released in standby unless kept alive.
        o_pin_oe[p] <= 1'b0;
        o_pin_out[p] <= 1'b0;
      end else begin
        // Ordinary output fields govern the pin.
        o_pin_oe[p] <= i_pin_oe[p];
        o_pin_out[p] <= i_pin_value[p];
      end
    end
  end

endmodule

// [logic/sbrc_standby_control.sv]
// Standby retention control with its AHB-Lite register slave.
// Function
// - Routing bit set drives standby on pin2.
// - Routed pin2 low in standby, high converting.
// - Routing clear: pin2 follows its output fields.
// - Diagnostics kept in standby only if bit set.
// - Keep oscillator for kept, enabled voltage errors, internal.
// - Oscillator may stop in standby when unneeded.
// - Outputs kept in standby only if bit set.
// - Switch keep clear opens switch in standby.
// - Switch keep set: channel setting decides switch.
module sbrc_standby_control #(
  parameter int NUM_PINS = 4,
  parameter int NUM_ERR = 4,
  parameter int NUM_CH = 4,
  parameter int CH_W = 2
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic o_hresp,
  input wire logic i_standby,
  input wire logic [CH_W-1:0] i_active_channel,
  output logic [NUM_PINS-1:0] o_pin_out,
  output logic [NUM_PINS-1:0] o_pin_oe,
  output logic [NUM_ERR-1:0] o_diag_active,
  output logic o_osc_run,
  output logic o_switch_close
);

  // Field widths are fixed by the register layout. Pins and error enables
  // each own one byte of their register, and the switch settings share
  // the low half word of theirs.
  if (NUM_PINS < 3 || NUM_PINS > sbrc_pkg::FIELD_W) begin : g_bad_pins
    $error("NUM_PINS must lie between 3 and 8");
  end
  if (NUM_ERR < 2 || NUM_ERR > sbrc_pkg::FIELD_W) begin : g_bad_err
    $error("NUM_ERR must lie between 2 and 8");
  end
  if (NUM_CH < 1 || NUM_CH > (1 << CH_W) || NUM_CH > 16) begin : g_bad_ch
    $error("NUM_CH must fit the channel select and 16 bits");
  end
  // A channel select needs at least one bit to pick a setting.
  if (CH_W < 1) begin : g_bad_ch_w
    $error("CH_W must be at least one");
  end
  // The keep-alive and routing bits must sit inside the stored word.
  if (sbrc_pkg::ROUTE_BIT >= sbrc_pkg::MISC_W) begin : g_bad_misc
    $error("routing bit lies outside the standby register");
  end

  // Bus slave phase and the request taken from the address phase.
  sbrc_pkg::sbrc_bus_state_type state_q;
  sbrc_pkg::sbrc_bus_state_type state_d;
  logic [7:0] idx_q;
  logic accept;
  logic wr_commit;

  // Stored register fields.
  logic [15:0] misc_q;
  logic [NUM_PINS-1:0] pin_oe_q;
  logic [NUM_PINS-1:0] pin_val_q;
  logic [NUM_ERR-1:0] err_en_q;
  logic [1:0] clk_sel_q;
  logic [NUM_CH-1:0] sw_set_q;

  // Registered read path.
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Decoded controls and the standby decisions built from them.
  logic route_en;
  logic diag_keep;
  logic out_keep;
  logic sw_keep;
  logic volt_err_en;
  logic osc_keep;
  logic sw_wanted;

  // The slave answers writes with no wait and reads with one wait state,
  // so read data always come from a register loaded after any write.
  // The wait state buys a registered read path: the multiplexer below
  // sees the index latched in the address phase and never the live bus.
  // Writes land at the end of their data phase, so a read that follows
  // directly still sees the new value. The response is always OKAY,
  // because nothing in this block can refuse a word.
  assign o_hreadyout = (state_q != sbrc_pkg::BUS_READ_WAIT);
  assign o_hresp = sbrc_pkg::HRESP_OKAY;
  assign o_hrdata = rdata_q;
  assign accept = i_hsel && i_hready
    && i_htrans[sbrc_pkg::TRANS_ACTIVE_BIT];
  assign wr_commit = (state_q == sbrc_pkg::BUS_WRITE);

  // Next phase of the bus slave. A read always passes through one wait
  // cycle; any other phase may take a new address phase at once, which
  // allows back to back transfers. An unused code falls back to idle,
  // so a corrupted phase can never hold the bus stalled.
  always_comb begin
    state_d = state_q;
    case (state_q)
      sbrc_pkg::BUS_READ_WAIT: begin
        state_d = sbrc_pkg::BUS_READ_DONE;
      end
      sbrc_pkg::BUS_IDLE,
      sbrc_pkg::BUS_WRITE,
      sbrc_pkg::BUS_READ_DONE: begin
        if (accept && i_hwrite) begin
          state_d = sbrc_pkg::BUS_WRITE;
        end else if (accept) begin
          state_d = sbrc_pkg::BUS_READ_WAIT;
        end else begin
          state_d = sbrc_pkg::BUS_IDLE;
        end
      end
      default: begin
        state_d = sbrc_pkg::BUS_IDLE;
      end
    endcase
  end

  // Bus phase and the latched register index. The index is kept from the
  // address phase because the write data only arrive one cycle later.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      state_q <= sbrc_pkg::BUS_IDLE;
      idx_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (accept) begin
        idx_q <= i_haddr[sbrc_pkg::WORD_LSB +: sbrc_pkg::IDX_W];
      end
    end
  end

  // Standby configuration register; reserved bits 12:9 stay zero.
  // Bits 15 to 13 and 4 to 0 are stored so software reads back what it
  // wrote, but nothing in this block acts on them.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      misc_q <= sbrc_pkg::MISC_RESET;
    end else if (wr_commit && idx_q == sbrc_pkg::IDX_MISC) begin
      misc_q <= i_hwdata[sbrc_pkg::MISC_W-1:0] & sbrc_pkg::MISC_WR_MASK;
    end
  end

  // Ordinary output enable and value fields for every pin. Pin 2 still
  // stores its fields while routing is on, so they apply again once the
  // routing bit is cleared.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      pin_oe_q <= '0;
      pin_val_q <= '0;
    end else if (wr_commit && idx_q == sbrc_pkg::IDX_IO_CTRL) begin
      pin_oe_q <= i_hwdata[sbrc_pkg::IO_OE_LSB +: NUM_PINS];
      pin_val_q <= i_hwdata[sbrc_pkg::IO_VAL_LSB +: NUM_PINS];
    end
  end

  // Error enables and the conversion clock source. Only the voltage error
  // enables and the clock select feed the oscillator decision.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      err_en_q <= '0;
      clk_sel_q <= sbrc_pkg::CLK_INTERNAL;
    end else if (wr_commit && idx_q == sbrc_pkg::IDX_DIAG_CTRL) begin
      err_en_q <= i_hwdata[sbrc_pkg::ERR_LSB +: NUM_ERR];
      clk_sel_q <= i_hwdata[sbrc_pkg::CLK_LSB +: sbrc_pkg::CLK_W];
    end
  end

  // Per-channel low-side switch settings; only the setting of the channel
  // that is active at the time is applied to the switch.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      sw_set_q <= '0;
    end else if (wr_commit && idx_q == sbrc_pkg::IDX_SWITCH_CTRL) begin
      sw_set_q <= i_hwdata[sbrc_pkg::SW_SET_LSB +: NUM_CH];
    end
  end

  // Decoded keep-alive and routing controls. They take effect on the
  // edge after the write, as every output below is registered.
  assign route_en = misc_q[sbrc_pkg::ROUTE_BIT];
  assign diag_keep = misc_q[sbrc_pkg::DIAG_KEEP_BIT];
  assign out_keep = misc_q[sbrc_pkg::OUT_KEEP_BIT];
  assign sw_keep = misc_q[sbrc_pkg::SW_KEEP_BIT];

  // The oscillator is only worth keeping for voltage checks that use it.
  // Keeping it for other diagnostics would cost standby current and buy
  // nothing, and an external clock needs no internal oscillator at all.
  assign volt_err_en = err_en_q[sbrc_pkg::ERR_OV_BIT]
    || err_en_q[sbrc_pkg::ERR_UV_BIT];
  assign osc_keep = diag_keep && volt_err_en
    && (clk_sel_q == sbrc_pkg::CLK_INTERNAL);
  // A channel number beyond the stored settings leaves the switch open,
  // so an oversized select field can never read past the setting bits.
  assign sw_wanted = (int'(i_active_channel) < NUM_CH)
    && sw_set_q[i_active_channel];

  // Diagnostics run while converting, and in standby only if kept.
  // Dropping them in standby is the low-power default after reset.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_diag_active <= '0;
    end else if (i_standby && !diag_keep) begin
      o_diag_active <= '0;
    end else begin
      o_diag_active <= err_en_q;
    end
  end

  // Stopping the oscillator in standby saves power; voltage detection
  // would misbehave without it, so it stays up when that is enabled and kept, on the internal clock.
  // It is requested at reset so conversions can start straight away.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_osc_run <= 1'b1;
    end else begin
      o_osc_run <= !i_standby || osc_keep;
    end
  end

  // Low-side switch: channel setting decides unless standby drops it.
  // Opening the switch in standby saves the bridge excitation current
  // while the converter is idle; software keeps it closed on purpose
  // only when a sensor must stay biased.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_switch_close <= 1'b0;
    end else if (i_standby && !sw_keep) begin
      o_switch_close <= 1'b0;
    end else begin
      o_switch_close <= sw_wanted;
    end
  end

  // General output pins, including the standby indication on pin 2.
  // The stage registers every pin, so a routed pin 2 follows standby one
  // edge late, in step with the other outputs of this block.
  sbrc_output_stage #(
    .NUM_PINS(NUM_PINS)
  ) u_output_stage (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_standby(i_standby),
    .i_route_en(route_en),
    .i_outputs_keep(out_keep),
    .i_pin_oe(pin_oe_q),
    .i_pin_value(pin_val_q),
    .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe)
  );

  // Read multiplexer; unmapped indexes read as zero. The status word shows
  // the registered outputs, so software sees what the pins really do,
  // including a routed pin 2 and any standby gating.
  always_comb begin
    rdata_d = sbrc_pkg::READ_ZERO;
    case (idx_q)
      sbrc_pkg::IDX_MISC: begin
        rdata_d[sbrc_pkg::MISC_W-1:0] = misc_q;
      end
      sbrc_pkg::IDX_IO_CTRL: begin
        rdata_d[sbrc_pkg::IO_OE_LSB +: NUM_PINS] = pin_oe_q;
        rdata_d[sbrc_pkg::IO_VAL_LSB +: NUM_PINS] = pin_val_q;
      end
      sbrc_pkg::IDX_DIAG_CTRL: begin
        rdata_d[sbrc_pkg::ERR_LSB +: NUM_ERR] = err_en_q;
        rdata_d[sbrc_pkg::CLK_LSB +: sbrc_pkg::CLK_W] = clk_sel_q;
      end
      sbrc_pkg::IDX_SWITCH_CTRL: begin
        rdata_d[sbrc_pkg::SW_SET_LSB +: NUM_CH] = sw_set_q;
      end
      sbrc_pkg::IDX_STATUS: begin
        rdata_d[sbrc_pkg::ST_STANDBY] = i_standby;
        rdata_d[sbrc_pkg::ST_OSC] = o_osc_run;
        rdata_d[sbrc_pkg::ST_SWITCH] = o_switch_close;
        rdata_d[sbrc_pkg::ST_ROUTE] = route_en;
        rdata_d[sbrc_pkg::ST_PIN_LSB +: NUM_PINS] = o_pin_out;
        rdata_d[sbrc_pkg::ST_OE_LSB +: NUM_PINS] = o_pin_oe;
      end
      default: begin
        rdata_d = sbrc_pkg::READ_ZERO;
      end
    endcase
  end

  // Read data are captured in the wait cycle and held until next read.
  // Holding them lets a slow master sample the word at any later edge.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      rdata_q <= sbrc_pkg::READ_ZERO;
    end else if (state_q == sbrc_pkg::BUS_READ_WAIT) begin
      rdata_q <= rdata_d;
    end
  end

endmodule

// [sim/sbrc_standby_sva.sv]
// Port-level assertion checker for the standby retention control block.
module sbrc_standby_sva #(
  parameter int NUM_PINS = 4,
  parameter int NUM_ERR = 4
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic i_standby,
  input wire logic [NUM_PINS-1:0] o_pin_oe,
  input wire logic [NUM_ERR-1:0] o_diag_active,
  input wire logic o_osc_run
);
  // Address phases taken at this edge, split by direction.
  wire logic rd_take = i_hsel & i_hready & i_htrans[1] & !i_hwrite;
  wire logic wr_take = i_hsel & i_hready & i_htrans[1] & i_hwrite;

  default clocking dc @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  a_reset_values:
    assert property ($rose(i_resetn) |-> o_osc_run && o_pin_oe == '0
      && o_diag_active == '0) else $error("outputs not at reset values");
  a_write_no_wait:
    assert property (wr_take |=> o_hreadyout)
      else $error("write data phase stalled");
  a_read_one_wait:
    assert property (rd_take |=> !o_hreadyout ##1 o_hreadyout)
      else $error("read wait is not one cycle");
  a_stall_cause:
    assert property (!o_hreadyout |-> $past(rd_take))
      else $error("stall without a read");
  a_resp_okay:
    assert property (o_hresp == 1'b0) else $error("response not okay");
  a_osc_converting:
    assert property ($past(i_resetn) && !$past(i_standby) |-> o_osc_run)
      else $error("oscillator stopped while converting");
  // The oscillator may only stay up in standby for a live voltage check.
  a_osc_needs_diag:
    assert property ($past(i_resetn) && $past(i_standby)
      && o_diag_active[1:0] == 2'h0 |-> !o_osc_run)
      else $error("oscillator kept without voltage diagnostics");
  a_pins_have_cause:
    assert property ($past(i_resetn) && $past(i_resetn, 2)
      && $changed(o_pin_oe) |-> $past(i_standby) != $past(i_standby, 2)
      || $past(wr_take, 3)) else $error("pin enables moved unprompted");

  c_read: cover property (rd_take);
  c_write: cover property (wr_take);
  c_osc_kept: cover property ($past(i_standby) && o_osc_run);
endmodule

bind sbrc_standby_control sbrc_standby_sva #(
  .NUM_PINS(NUM_PINS), .NUM_ERR(NUM_ERR)
) sbrc_standby_sva_inst (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_hsel(i_hsel),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_standby(i_standby),
  .o_pin_oe(o_pin_oe), .o_diag_active(o_diag_active),
  .o_osc_run(o_osc_run)
);

// [sim/tb.sv]
// Self-checking bench for the standby retention control block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic st;
    logic [15:0] misc, io, diag;
    logic [3:0] sw;
    logic [1:0] ch;
    logic [3:0] po, oe, dg;
    logic osc, sc;
  } sbrc_row_type;
  // Fields: standby, misc, io, diag, switch, channel, then expectations.
  localparam sbrc_row_type ROWS [7] = '{
    '{1'h0,16'h0000,16'h0e0f,16'h0001,4'h2,2'h1,4'he,4'hf,4'h1,1'h1,1'h1},
    '{1'h1,16'h0000,16'h0e0f,16'h0001,4'h2,2'h1,4'h0,4'h0,4'h0,1'h0,1'h0},
    '{1'h1,16'h01e0,16'h0e0f,16'h0002,4'h2,2'h1,4'ha,4'hf,4'h2,1'h1,1'h1},
    '{1'h0,16'h0100,16'h0000,16'h0001,4'h2,2'h1,4'h4,4'h4,4'h1,1'h1,1'h1},
    '{1'h1,16'h0080,16'h0e0f,16'h0101,4'h2,2'h1,4'h0,4'h0,4'h1,1'h0,1'h0},
    '{1'h1,16'h00a0,16'h0e0f,16'h0004,4'h2,2'h1,4'h0,4'h0,4'h4,1'h0,1'h1},
    '{1'h1,16'h0120,16'h0e0f,16'h0000,4'h2,2'h0,4'h0,4'h4,4'h0,1'h0,1'h0}};
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic i_hsel = 1'b0;
  logic i_hwrite = 1'b0;
  logic i_standby = 1'b0;
  logic [1:0] i_htrans = 2'h0;
  logic [1:0] i_active_channel = 2'h0;
  logic [2:0] i_hsize = 3'h2;
  logic [31:0] i_haddr = 32'h0;
  logic [31:0] i_hwdata = 32'h0;
  logic [31:0] rdata;
  logic o_hreadyout, o_hresp, o_osc_run, o_switch_close;
  logic [31:0] o_hrdata;
  logic [3:0] o_pin_out, o_pin_oe, o_diag_active;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  sbrc_row_type r;
  logic [13:0] want;
  wire logic [13:0] outs = {o_pin_out, o_pin_oe, o_diag_active, o_osc_run,
    o_switch_close};

  sbrc_standby_control sbrc_standby_control_inst (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
    .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata), .o_hresp(o_hresp),
    .i_standby(i_standby), .i_active_channel(i_active_channel),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
    .o_diag_active(o_diag_active), .o_osc_run(o_osc_run),
    .o_switch_close(o_switch_close));

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // One single word transfer; the slave may stall, so every wait polls.
  task automatic bus(input logic w, input logic [7:0] idx,
    input logic [31:0] d);
    @(posedge i_clock);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_hwrite <= w;
    i_haddr <= {22'h0, idx, 2'h0};
    do @(posedge i_clock); while (o_hreadyout !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_clock); while (o_hreadyout !== 1'b1);
    rdata = o_hrdata;
  endtask

  initial begin
    forever #10 i_clock = ~i_clock;
  end

  // A hang ends the run as a failure instead of stalling forever.
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge i_clock);
    i_resetn <= 1'b1;
    @(posedge i_clock);
    foreach (ROWS[k]) begin
      r = ROWS[k];
      bus(1'b1, sbrc_pkg::IDX_MISC, 32'(r.misc));
      bus(1'b1, sbrc_pkg::IDX_IO_CTRL, 32'(r.io));
      bus(1'b1, sbrc_pkg::IDX_DIAG_CTRL, 32'(r.diag));
      bus(1'b1, sbrc_pkg::IDX_SWITCH_CTRL, 32'(r.sw));
      i_standby <= r.st;
      i_active_channel <= r.ch;
      repeat (3) @(posedge i_clock);
      want = {r.po, r.oe, r.dg, r.osc, r.sc};
      chk(32'(outs), 32'(want));
    end
    bus(1'b1, sbrc_pkg::IDX_MISC, 32'hffff_ffff);
    bus(1'b0, sbrc_pkg::IDX_MISC, 32'h0);
    chk(rdata, 32'h0000_e1ff);
    bus(1'b0, sbrc_pkg::IDX_STATUS, 32'h0);
    chk(rdata, 32'h000f_0a09);
    bus(1'b0, 8'h00, 32'h0);
    chk(rdata, 32'h0);
    // Reset in mid-run must clear every keep and routing bit.
    i_standby <= 1'b0;
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_resetn <= 1'b1;
    @(posedge i_clock);
    chk(32'(outs), 32'h2);
    bus(1'b0, sbrc_pkg::IDX_MISC, 32'h0);
    chk(rdata, 32'h0);
    give_verdict();
  end
endmodule
